// ### dv/lsc_host_model.sv
/*
  serial-bus host model: master that frames starts, stops and bytes.
  assumes a pull-up on sda and a slave far faster than the 125 ns link period.
*/
`timescale 1ns/100ps
module lsc_host_model
(
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_oe_out
);
  // quarter link periods, split so four make exactly 125 ns at 100 ps precision;
  // data moves mid-low so it is settled at both scl edges
  localparam realtime QTR_A = 31.2;
  localparam realtime QTR_B = 31.3;

  // scl stands high between frames
  initial
  begin
    scl_out    = 1'b1;
    sda_oe_out = 1'b0;
  end

  task automatic start_bit();
    // 1 ns lead keeps every link edge off the system clock edges
    #1 sda_oe_out = 1'b0;
    #QTR_A scl_out = 1'b1;
    #QTR_B sda_oe_out = 1'b1;
    #QTR_A scl_out = 1'b0;
  endtask : start_bit

  task automatic clock_bit(input logic b, output logic s);
    #QTR_A sda_oe_out = !b;
    #QTR_B scl_out = 1'b1;
    #QTR_A s = sda_in;
    #QTR_B scl_out = 1'b0;
  endtask : clock_bit

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      clock_bit(b[i], s);
    end
    clock_bit(1'b1, s);
    ack = !s;
  endtask : send_byte

  // host ack on all but the last byte read
  task automatic recv_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      clock_bit(1'b1, d[i]);
    end
    clock_bit(last, s);
  endtask : recv_byte

  task automatic stop_bit();
    #QTR_A sda_oe_out = 1'b1;
    #QTR_B scl_out = 1'b1;
    #QTR_A sda_oe_out = 1'b0;
    #QTR_B;
  endtask : stop_bit
endmodule : lsc_host_model

// ### dv/test_lsc_supply_ctrl.sv
/*
  self-checking bench of the supply-control block: serial-bus writes and reads
  through a host model, pins and analog flags driven at the falling clock edge.
  assumes short dynamic limit counts set by parameter.
*/
`timescale 1ns/100ps
module test_lsc_supply_ctrl
  import lsc_pkg::*;
;
  localparam int ON = 20;
  localparam int OFF = 1000;
  localparam logic [1:0] SEL = 2'h2;

  logic       clk = 1'b0;
  logic       srst = 1'b1;
  logic [1:0] addr_sel = SEL;
  logic       raise = 1'b0;
  logic       ext = 1'b0;
  logic       ot = 1'b0;
  logic       oc = 1'b0;
  logic       ov = 1'b0;
  logic       uv = 1'b0;
  logic       scl, host_oe, dut_sda, dut_oe, conv_en, out_en, stat_lim, tone, fault_n;
  logic [1:0] vcode, lim;
  wire        sda_line = !(host_oe | (dut_oe & !dut_sda));
  int         err_total = 0;
  int         checks = 0;
  int         cyc = 0;

  always #5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  lsc_host_model host_model (.sda_in(sda_line), .scl_out(scl), .sda_oe_out(host_oe));

  lsc_supply_ctrl #(.DYN_ON_CYCLES(ON), .DYN_OFF_CYCLES(OFF)) DUT (
    .sys_clk_in(clk), .srst_in(srst), .i2c_scl_in(scl), .i2c_sda_in(sda_line),
    .i2c_sda_out(dut_sda), .i2c_sda_oe_out(dut_oe), .addr_sel_in(addr_sel),
    .range_raise_pin_in(raise), .external_tone_mod_input_in(ext),
    .overtemp_in(ot), .overcurrent_in(oc), .overvoltage_in(ov), .undervoltage_in(uv),
    .converter_enable_out(conv_en), .output_enable_out(out_en), .vout_code_out(vcode),
    .limit_level_out(lim), .static_limit_out(stat_lim), .tone_out(tone),
    .fault_interrupt_n_out(fault_n));

  task automatic report_and_stop();
    if (err_total == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  task automatic chk1(input logic got, input logic exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk1

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk8

  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask : settle

  task automatic wr(input logic [1:0] sel, input logic [7:0] d, input logic exp_ack);
    logic a;
    host_model.start_bit();
    host_model.send_byte({I2C_ADDR_FIXED, sel, 1'b0}, a);
    chk1(a, exp_ack);
    if (a)
      host_model.send_byte(d, a);
    host_model.stop_bit();
    settle(8);
  endtask : wr

  task automatic rd(output logic [7:0] c, output logic [7:0] s);
    logic a;
    host_model.start_bit();
    host_model.send_byte({I2C_ADDR_FIXED, SEL, 1'b1}, a);
    host_model.recv_byte(1'b0, c);
    host_model.recv_byte(1'b1, s);
    host_model.stop_bit();
    settle(4);
  endtask : rd

  // bounded wait; a stuck output shows up as a count of 2000
  task automatic wait_oe(input logic lvl, output int n);
    n = 0;
    while (out_en !== lvl && n < 2000)
    begin
      @(negedge clk);
      n++;
    end
  endtask : wait_oe

  task automatic count_tog(input int n, output int t);
    logic p;
    t = 0;
    p = tone;
    repeat (n)
    begin
      @(negedge clk);
      if (tone !== p)
        t++;
      p = tone;
    end
  endtask : count_tog

  initial
  begin
    #400_000;
    err_total++;
    report_and_stop();
  end

  initial
  begin
    logic [7:0] c, s, d;
    logic [1:0] v;
    int         n, t0;
    repeat (2) @(posedge clk);
    @(negedge clk) srst = 1'b0;
    settle(6);
    chk1(fault_n, 1'b0);
    chk1(conv_en, 1'b0);
    rd(c, s);
    chk8(c, CTRL_RST);
    chk8(s, 8'h01);
    wr(2'h1, 8'hff, 1'b0);
    addr_sel = 2'h1;
    wr(2'h1, 8'h80, 1'b1);
    chk1(out_en, 1'b1);
    addr_sel = SEL;
    for (int i = 0; i < 4; i++)
    begin
      v = i[1:0];
      d = {1'b1, v, 5'h00};
      wr(SEL, d, 1'b1);
      chk8({6'h00, vcode}, {6'h00, v});
      @(negedge clk) raise = 1'b1;
      settle(6);
      chk8({6'h00, vcode}, {6'h00, 1'b1, v[0]});
      rd(c, s);
      chk8(c, d);
      raise = 1'b0;
      d = {4'h8, v, 2'h0};
      wr(SEL, d, 1'b1);
      chk8({6'h00, lim}, {6'h00, v});
      chk1(stat_lim, 1'b0);
    end
    wr(SEL, 8'h9c, 1'b1);
    chk1(stat_lim, 1'b1);
    oc = 1'b1;
    settle(200);
    chk1(out_en, 1'b1);
    oc = 1'b0;
    wr(SEL, 8'h80, 1'b1);
    oc = 1'b1;
    wait_oe(1'b0, n);
    chk1(n >= ON && n <= ON + 4, 1'b1);
    chk1(fault_n, 1'b0);
    t0 = cyc;
    rd(c, s);
    chk8(s, 8'h04);
    wait_oe(1'b1, n);
    chk1(cyc - t0 >= OFF - 1 && cyc - t0 <= OFF + 1, 1'b1);
    wait_oe(1'b0, n);
    chk1(n >= ON - 1 && n <= ON + 1, 1'b1);
    oc = 1'b0;
    wait_oe(1'b1, n);
    settle(2);
    chk1(fault_n, 1'b1);
    ov = 1'b1;
    uv = 1'b1;
    settle(6);
    rd(c, s);
    chk8(s, 8'h18);
    ov = 1'b0;
    uv = 1'b0;
    ot = 1'b1;
    settle(6);
    chk1(out_en, 1'b0);
    chk1(fault_n, 1'b0);
    rd(c, s);
    chk8(s, 8'h02);
    ot = 1'b0;
    settle(6);
    chk1(fault_n, 1'b1);
    wr(SEL, 8'h00, 1'b1);
    chk1(conv_en, 1'b0);
    chk1(out_en, 1'b0);
    chk1(fault_n, 1'b0);
    wr(SEL, 8'h81, 1'b1);
    ext = 1'b1;
    settle(6);
    chk1(tone, 1'b1);
    ext = 1'b0;
    settle(6);
    chk1(tone, 1'b0);
    wr(SEL, 8'h83, 1'b1);
    ext = 1'b1;
    count_tog(3 * TONE_HALF_CYC + 20, n);
    chk1(n >= 2 && n <= 4, 1'b1);
    ext = 1'b0;
    settle(10);
    count_tog(TONE_HALF_CYC + 10, n);
    chk1(n == 0 && tone === 1'b0, 1'b1);
    report_and_stop();
  end
endmodule : test_lsc_supply_ctrl

// ### rtl/lsc_i2c_slave.sv
/*
  serial-bus slave: byte writes into the control register, byte reads of
  control then diagnostics. assumes scl/sda arrive asynchronously and that
  the bus is far slower than the system clock.
*/
`timescale 1ns/100ps
module lsc_i2c_slave
  import lsc_pkg::*;
(
  input  wire logic       sys_clk_in,
  input  wire logic       srst_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  input  wire logic [1:0] addr_sel_in,
  input  wire logic [7:0] rd_data_in,
  output logic            sda_out,
  output logic            sda_oe_out,
  output logic            wr_valid_out,
  output logic [7:0]      wr_data_out,
  output logic            rd_sel_out
);

  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic       scl_q;
  logic       sda_q;
  lsc_i2c_e   state;
  lsc_i2c_e   next_state;
  logic [3:0] bit_cnt;
  logic [3:0] next_cnt;
  logic [7:0] shift;
  logic [7:0] next_shift;
  logic       rw;
  logic       next_rw;
  logic       nack;
  logic       next_nack;
  logic       next_sel;
  logic       next_oe;
  logic       next_wr;

  wire scl_rise  = scl_sync[1] & ~scl_q;
  wire scl_fall  = ~scl_sync[1] & scl_q;
  wire bus_start = scl_sync[1] & scl_q & sda_q & ~sda_sync[1];
  wire bus_stop  = scl_sync[1] & scl_q & ~sda_q & sda_sync[1];
  wire [6:0] own_addr = {I2C_ADDR_FIXED, addr_sel_in};
  wire addr_hit  = (shift[7:1] == own_addr);
  wire byte_done = scl_fall && (bit_cnt == 4'h8);

  assign sda_out     = 1'b0;
  assign wr_data_out = shift;

  always_comb
  begin
    next_state = state;
    next_cnt   = bit_cnt;
    next_shift = shift;
    next_rw    = rw;
    next_nack  = nack;
    next_sel   = rd_sel_out;
    next_oe    = sda_oe_out;
    next_wr    = 1'b0;
    if (bus_start)
    begin
      next_state = I2C_ADDR;
      next_cnt   = 4'h0;
      next_oe    = 1'b0;
      next_sel   = RD_CTRL;
    end
    else if (bus_stop)
    begin
      next_state = I2C_IDLE;
      next_oe    = 1'b0;
    end
    else
    begin
      unique case (state)
        I2C_IDLE: next_state = I2C_IDLE;
        I2C_ADDR, I2C_WRITE:
        begin
          if (scl_rise)
          begin
            next_shift = {shift[6:0], sda_sync[1]};
            next_cnt   = bit_cnt + 4'h1;
          end
          else if (byte_done && state == I2C_ADDR)
          begin
            next_state = addr_hit ? I2C_ACKA : I2C_IDLE;
            next_rw    = shift[0];
            next_oe    = addr_hit;
          end
          else if (byte_done)
          begin
            next_wr    = 1'b1;
            next_state = I2C_ACKW;
            next_oe    = 1'b1;
          end
        end
        I2C_ACKA, I2C_ACKW:
        begin
          if (scl_fall)
          begin
            next_cnt   = 4'h0;
            next_shift = rd_data_in;
            next_oe    = rw && state == I2C_ACKA && !rd_data_in[7];
            next_state = (rw && state == I2C_ACKA) ? I2C_READ : I2C_WRITE;
          end
        end
        I2C_READ:
        begin
          if (scl_rise)
            next_cnt = bit_cnt + 4'h1;
          else if (byte_done)
          begin
            next_oe    = 1'b0;
            next_state = I2C_ACKR;
          end
          else if (scl_fall)
          begin
            next_shift = {shift[6:0], 1'b0};
            next_oe    = !shift[6];
          end
        end
        I2C_ACKR:
        begin
          if (scl_rise)
          begin
            next_nack = sda_sync[1];
            next_sel  = RD_STAT;
          end
          else if (scl_fall)
          begin
            next_cnt   = 4'h0;
            next_shift = rd_data_in;
            next_oe    = !nack && !rd_data_in[7];
            next_state = nack ? I2C_IDLE : I2C_READ;
          end
        end
        default: next_state = I2C_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      scl_sync     <= 2'h3;
      sda_sync     <= 2'h3;
      scl_q        <= 1'b1;
      sda_q        <= 1'b1;
      state        <= I2C_IDLE;
      bit_cnt      <= 4'h0;
      shift        <= 8'h00;
      rw           <= 1'b0;
      nack         <= 1'b0;
      rd_sel_out   <= RD_CTRL;
      sda_oe_out   <= 1'b0;
      wr_valid_out <= 1'b0;
    end
    else
    begin
      scl_sync     <= {scl_sync[0], scl_in};
      sda_sync     <= {sda_sync[0], sda_in};
      scl_q        <= scl_sync[1];
      sda_q        <= sda_sync[1];
      state        <= next_state;
      bit_cnt      <= next_cnt;
      shift        <= next_shift;
      rw           <= next_rw;
      nack         <= next_nack;
      rd_sel_out   <= next_sel;
      sda_oe_out   <= next_oe;
      wr_valid_out <= next_wr;
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);

  addr_ack_a: assert property (state == I2C_ADDR && byte_done && !bus_start && !bus_stop
    |=> (state == I2C_ACKA) == $past(addr_hit) && sda_oe_out == $past(addr_hit))
    else $error("address acknowledge does not follow the address match");
  write_strobe_a: assert property (wr_valid_out |-> state == I2C_ACKW && $past(bit_cnt) == 4'h8)
    else $error("write strobe outside a completed data byte");

endmodule : lsc_i2c_slave

// ### rtl/lsc_pkg.sv
/*
  constants and state types shared by the supply-control register block
  and its serial-bus slave. assumes a 100 MHz system clock.
*/
package lsc_pkg;

  // timing
  localparam int CLK_HZ        = 100_000_000;
  localparam int TONE_HZ       = 22_000;
  localparam int TONE_HALF_CYC = CLK_HZ / (2 * TONE_HZ);
  localparam int DYN_ON_MS     = 51;
  localparam int DYN_OFF_MS    = 900;
  localparam int DYN_ON_CYC    = DYN_ON_MS * (CLK_HZ / 1000);
  localparam int DYN_OFF_CYC   = DYN_OFF_MS * (CLK_HZ / 1000);

  // slave address: upper five bits fixed, two low bits from pins
  localparam logic [4:0] I2C_ADDR_FIXED = 5'h04;

  // system_control_register fields
  localparam int CTL_EN    = 7;
  localparam int CTL_HV    = 6;
  localparam int CTL_LV    = 5;
  localparam int CTL_DCL   = 4;
  localparam int CTL_IMSB  = 3;
  localparam int CTL_ILSB  = 2;
  localparam int CTL_TGATE = 1;
  localparam int CTL_TONE  = 0;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // diagnostic byte fields, bits 7:5 read zero
  localparam int ST_OV  = 4;
  localparam int ST_UV  = 3;
  localparam int ST_OL  = 2;
  localparam int ST_OT  = 1;
  localparam int ST_OFF = 0;
  localparam logic [7:0] STAT_RST = 8'h00;

  // read byte select
  localparam logic RD_CTRL = 1'b0;
  localparam logic RD_STAT = 1'b1;

  typedef enum logic [6:0] {
    I2C_IDLE  = 7'h01,
    I2C_ADDR  = 7'h02,
    I2C_ACKA  = 7'h04,
    I2C_WRITE = 7'h08,
    I2C_ACKW  = 7'h10,
    I2C_READ  = 7'h20,
    I2C_ACKR  = 7'h40
  } lsc_i2c_e;

  typedef enum logic [3:0] {
    PWR_OFF   = 4'h1,
    PWR_ON    = 4'h2,
    PWR_LIMIT = 4'h4,
    PWR_REST  = 4'h8
  } lsc_pwr_e;

endpackage : lsc_pkg

// ### rtl/lsc_supply_ctrl.sv
/*
  control and diagnostic register block of a dish supply regulator: serial
  bus registers, voltage select, current limit, tone path, fault line.
  assumes all status inputs and pins are asynchronous to sys_clk_in and
  that the analog converter obeys the enables and codes driven here.
*/
// Operation
// - host configures everything by 8-bit writes
// - written register contents read back unchanged
// - readback carries five diagnostic status bits
// - cleared enable shuts converter and output
// - four selectable overcurrent limit levels
// - two select bits choose voltage, range pin can force the high bit
// - range pin raises lower range to higher
// - external tone waveform reproduced on output
// - external input can gate internal tone
// - fault line low on shutdown of output
// - host reads cause of shutdown
// - slave address fixed upper, selectable lower
// - dynamic limit: 51 ms on, 900 ms off
// - limit codes 00..11 lowest to highest
`timescale 1ns/100ps
module lsc_supply_ctrl
  import lsc_pkg::*;
#(
  parameter int DYN_ON_CYCLES  = DYN_ON_CYC,
  parameter int DYN_OFF_CYCLES = DYN_OFF_CYC
)
(
  input  wire logic       sys_clk_in,
  input  wire logic       srst_in,
  input  wire logic       i2c_scl_in,
  input  wire logic       i2c_sda_in,
  output logic            i2c_sda_out,
  output logic            i2c_sda_oe_out,
  input  wire logic [1:0] addr_sel_in,
  input  wire logic       range_raise_pin_in,
  input  wire logic       external_tone_mod_input_in,
  input  wire logic       overtemp_in,
  input  wire logic       overcurrent_in,
  input  wire logic       overvoltage_in,
  input  wire logic       undervoltage_in,
  output logic            converter_enable_out,
  output logic            output_enable_out,
  output logic [1:0]      vout_code_out,
  output logic [1:0]      limit_level_out,
  output logic            static_limit_out,
  output logic            tone_out,
  output logic            fault_interrupt_n_out
);

  localparam int CNT_W  = $clog2(DYN_OFF_CYCLES > DYN_ON_CYCLES ?
                                 DYN_OFF_CYCLES + 1 : DYN_ON_CYCLES + 1);
  localparam int TONE_W = $clog2(TONE_HALF_CYC + 1);

  logic [7:0]        in_sync1;
  logic [7:0]        in_sync2;
  logic [7:0]        system_control_register;
  logic [7:0]        status;
  lsc_pwr_e          state;
  lsc_pwr_e          next_state;
  logic [CNT_W-1:0]  dyn_cnt;
  logic [CNT_W-1:0]  next_dyn_cnt;
  logic [TONE_W-1:0] tone_div;
  logic              tone_int;
  logic              wr_valid;
  logic [7:0]        wr_data;
  logic              rd_sel;
  logic              raise_s;
  logic              ext_s;
  logic              ot_s;
  logic              oc_s;
  logic              ov_s;
  logic              uv_s;
  logic [1:0]        addr_s;

  // every status, range, tone and address pin passes two flops before use
  assign {raise_s, ext_s, ot_s, oc_s, ov_s, uv_s, addr_s} = in_sync2;

  wire enable_bit              = system_control_register[CTL_EN];
  wire high_voltage_select_bit = system_control_register[CTL_HV];
  wire low_voltage_select_bit  = system_control_register[CTL_LV];
  wire static_limit_select     = system_control_register[CTL_DCL];
  wire current_level_select_msb = system_control_register[CTL_IMSB];
  wire current_level_select_lsb = system_control_register[CTL_ILSB];
  wire tone_gate_mode          = system_control_register[CTL_TGATE];
  wire tone_on_bit             = system_control_register[CTL_TONE];

  wire run_ok      = enable_bit && !ot_s;
  wire next_out_on = (next_state == PWR_ON) || (next_state == PWR_LIMIT);
  wire on_last     = (dyn_cnt == CNT_W'(DYN_ON_CYCLES - 1));
  wire off_last    = (dyn_cnt == CNT_W'(DYN_OFF_CYCLES - 1));
  wire tone_wrap   = (tone_div == TONE_W'(TONE_HALF_CYC - 1));

  wire [1:0] next_vcode = {high_voltage_select_bit | raise_s, low_voltage_select_bit};

  wire tone_src  = tone_gate_mode ? (tone_int & ext_s) : ext_s;
  wire next_tone = tone_on_bit & tone_src & next_out_on;

  wire [7:0] next_status = {3'h0, ov_s, uv_s, oc_s || state == PWR_REST, ot_s, !enable_bit};

  wire [7:0] rd_data = (rd_sel == RD_STAT) ? status : system_control_register;

  lsc_i2c_slave u_slave (
    .sys_clk_in   (sys_clk_in),
    .srst_in      (srst_in),
    .scl_in       (i2c_scl_in),
    .sda_in       (i2c_sda_in),
    .addr_sel_in  (addr_s),
    .rd_data_in   (rd_data),
    .sda_out      (i2c_sda_out),
    .sda_oe_out   (i2c_sda_oe_out),
    .wr_valid_out (wr_valid),
    .wr_data_out  (wr_data),
    .rd_sel_out   (rd_sel)
  );

  always_comb
  begin
    next_state   = state;
    next_dyn_cnt = dyn_cnt;
    unique case (state)
      PWR_OFF:
      begin
        next_dyn_cnt = '0;
        if (run_ok)
          next_state = PWR_ON;
      end
      PWR_ON:
      begin
        next_dyn_cnt = '0;
        if (!run_ok)
          next_state = PWR_OFF;
        else if (oc_s && !static_limit_select)
          next_state = PWR_LIMIT;
      end
      PWR_LIMIT:
      begin
        next_dyn_cnt = dyn_cnt + CNT_W'(1);
        if (!run_ok)
          next_state = PWR_OFF;
        else if (!oc_s || static_limit_select)
          next_state = PWR_ON;
        else if (on_last)
        begin
          next_state   = PWR_REST;
          next_dyn_cnt = '0;
        end
      end
      PWR_REST:
      begin
        next_dyn_cnt = dyn_cnt + CNT_W'(1);
        if (!run_ok)
          next_state = PWR_OFF;
        else if (off_last)
          next_state = PWR_ON;
      end
      default:
        next_state = PWR_OFF;
    endcase
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      in_sync1 <= 8'h00;
      in_sync2 <= 8'h00;
    end
    else
    begin
      in_sync1 <= {range_raise_pin_in, external_tone_mod_input_in, overtemp_in,
                   overcurrent_in, overvoltage_in, undervoltage_in, addr_sel_in};
      in_sync2 <= in_sync1;
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      system_control_register <= CTRL_RST;
    else if (wr_valid)
      system_control_register <= wr_data;
  end

  // tone divider free-runs, so bursts start at whatever phase the divider has reached
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      tone_div <= '0;
      tone_int <= 1'b0;
    end
    else
    begin
      tone_div <= tone_wrap ? '0 : tone_div + TONE_W'(1);
      tone_int <= tone_int ^ tone_wrap;
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      state   <= PWR_OFF;
      dyn_cnt <= '0;
      status  <= STAT_RST;
    end
    else
    begin
      state   <= next_state;
      dyn_cnt <= next_dyn_cnt;
      status  <= next_status;
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      converter_enable_out  <= 1'b0;
      output_enable_out     <= 1'b0;
      vout_code_out         <= 2'h0;
      limit_level_out       <= 2'h0;
      static_limit_out      <= 1'b0;
      tone_out              <= 1'b0;
      fault_interrupt_n_out <= 1'b0;
    end
    else
    begin
      converter_enable_out  <= run_ok;
      output_enable_out     <= next_out_on;
      vout_code_out         <= next_vcode;
      limit_level_out       <= {current_level_select_msb, current_level_select_lsb};
      static_limit_out      <= static_limit_select;
      tone_out              <= next_tone;
      fault_interrupt_n_out <= next_out_on;
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);

  sequence limit_expire_s;
    state == PWR_LIMIT && run_ok && oc_s && !static_limit_select && on_last;
  endsequence
  sequence rest_start_s;
    state == PWR_REST && dyn_cnt == '0 && !output_enable_out && !fault_interrupt_n_out;
  endsequence
  sequence rest_expire_s;
    state == PWR_REST && run_ok && off_last;
  endsequence

  reg_write_a: assert property (wr_valid |=> system_control_register == $past(wr_data))
    else $error("control register did not take the written byte");
  standby_off_a: assert property (!enable_bit |=> !output_enable_out && !converter_enable_out)
    else $error("output still on with enable cleared");
  limit_level_a: assert property (##1 limit_level_out == $past(system_control_register[3:2]))
    else $error("limit level does not follow the select bits");
  vout_sel_a: assert property (!raise_s |=> vout_code_out == $past(system_control_register[6:5]))
    else $error("voltage code does not follow the select bits");
  raise_pin_a: assert property (raise_s |=> vout_code_out[1])
    else $error("range pin did not lift the output range");
  tone_pass_a: assert property (tone_on_bit && !tone_gate_mode && next_out_on
    |=> tone_out == $past(ext_s))
    else $error("external tone waveform not reproduced");
  tone_gate_a: assert property (tone_gate_mode && !ext_s |=> !tone_out)
    else $error("internal tone not gated off by the external input");
  fault_set_a: assert property (!run_ok |=> !fault_interrupt_n_out ##1
    (!fault_interrupt_n_out || $past(run_ok)))
    else $error("fault line not asserted on shutdown");
  diag_bits_a: assert property ($rose(ot_s) |=> status[ST_OT] && !fault_interrupt_n_out)
    else $error("overtemperature not reported");
  off_cause_a: assert property (!enable_bit |=> status[ST_OFF])
    else $error("disable cause not readable");
  dyn_on_a: assert property (limit_expire_s |=> rest_start_s)
    else $error("overload on-time did not end in the off interval");
  dyn_off_a: assert property (rest_expire_s |=> state == PWR_ON && output_enable_out)
    else $error("output not retried after the off interval");
  fault_clear_a: assert property (state == PWR_OFF && run_ok ##1 !oc_s && run_ok
    |=> fault_interrupt_n_out)
    else $error("fault line not released after clean re-enable");
  code_order_a: assert property (wr_valid && wr_data[3:2] == 2'h3 |=> ##1 limit_level_out == 2'h3)
    else $error("highest limit code not passed through");
  conv_on_a: assert property (enable_bit && !ot_s |=> converter_enable_out)
    else $error("converter not enabled although running is allowed");
  tone_off_a: assert property (!tone_on_bit |=> !tone_out)
    else $error("tone driven with the tone enable cleared");
  diag_live_a: assert property (##1 status[ST_OV] == $past(ov_s)
    && status[ST_UV] == $past(uv_s))
    else $error("overvoltage or undervoltage flag not reported");

endmodule : lsc_supply_ctrl
